//--- logic/link_stop_pkg.sv
// Purpose: constants and types for the link stop / disconnect state logic
// Assumes: 200 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   times are kept in their own unit and converted to cycles here
//
// Behaviour
// - stop request during normal operation moves the link into stop-disconnect
// - stop-disconnect keeps scrambling on all lanes and holds the clock frequency
// - receiver DLL stays locked; valid packets processed until disconnect packet arrives
// - entering stop-disconnect freezes the ack pointer and clears this link's credits
// - phase recovery prepares to hold the data eye within 100ns
// - restart signal in stop-disconnect or disconnected goes straight to warm reset
// - finish current packet, send disconnect packets 200 to 300ns (longer until four are out), then disconnect
// - at least four disconnect packets are always sent before disconnecting
// - disconnect packets may stop mid-packet but the link never goes static
// - disconnected is entered when stop-disconnect completes
// - transmitter follows its low-power select; PLL relocks on a new frequency
// - divided-clock state runs the transmit clock divided, glitch-free, never faster
// - low-power states 1, 2, 3 disable the control and data lane inputs
// - states 2 and 3 also disable clock input; select 11b acts as Phy_powered_down_state
// - DLL stays locked unless state 2/3 or frequency changes; relocks on change
// - reduced width places the unused lanes in the inactive state while disconnected
// - disconnected with transmit-off set moves the link into Phy_powered_down_state
// - transmit clock returns to active at programmed frequency within 900ns
// - receiver waits 1000ns before tracking, seeking the eye and training
// - idle time over its maximum forces the full 200us first training state
// - slow clock restore forces bit 1 of both low-power selects to zero
// - phase recovery seeks lock only in the first training state, which ends on its timer
// - idle timer measures disconnected time against a characterised maximum

package link_stop_pkg;

	localparam int unsigned CLK_MHZ       = 200;
	localparam int unsigned PHASE_PREP_NS = 100;
	localparam int unsigned DISC_MIN_NS   = 200;
	localparam int unsigned DISC_MAX_NS   = 300;
	localparam int unsigned TX_RESTORE_NS = 900;
	localparam int unsigned RX_WAIT_NS    = 1000;
	localparam int unsigned FULL_T0_US    = 200;
	// least times round up, longest times round down
	localparam int unsigned PHASE_PREP_CYC = (PHASE_PREP_NS * CLK_MHZ) / 1000;
	localparam int unsigned DISC_MIN_CYC   = (DISC_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DISC_MAX_CYC   = (DISC_MAX_NS * CLK_MHZ) / 1000;
	localparam int unsigned TX_RESTORE_CYC = (TX_RESTORE_NS * CLK_MHZ) / 1000;
	localparam int unsigned RX_WAIT_CYC    = (RX_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned FULL_T0_CYC    = FULL_T0_US * CLK_MHZ;
	localparam int unsigned DISC_MIN_PKTS  = 4;

	// register byte offsets
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] SHORT_T0_OFS = 12'h004;
	localparam logic [11:0] IDLE_MAX_OFS = 12'h008;
	localparam logic [11:0] STATUS_OFS   = 12'h00c;
	localparam logic [11:0] IDLE_CNT_OFS = 12'h010;

	// control register fields
	localparam int unsigned TRANSMIT_OFF_CTL_BIT  = 0;
	localparam int unsigned TXSEL_LSB  = 1;
	localparam int unsigned RXSEL_LSB  = 3;
	localparam int unsigned FREQ_BIT   = 5;
	localparam int unsigned NARROW_BIT = 6;
	localparam int unsigned DIVCLK_BIT = 7;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [31:0] SHORT_T0_RST = 32'h0000_0028;
	localparam logic [31:0] IDLE_MAX_RST = 32'hffff_ffff;

	// low-power select encodings
	localparam logic [1:0] LS0 = 2'h0;
	localparam logic [1:0] LS1 = 2'h1;
	localparam logic [1:0] LS2 = 2'h2;
	localparam logic [1:0] LS3 = 2'h3;

	// transmit clock modes
	localparam logic [1:0] TRANSMIT_CLOCK_PROG = 2'h0;
	localparam logic [1:0] TRANSMIT_CLOCK_DIV  = 2'h1;
	localparam logic [1:0] TRANSMIT_CLOCK_STOP = 2'h2;
	localparam logic [1:0] TRANSMIT_CLOCK_HOLD = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_OPER,
		ST_STOP,
		ST_SEND_DISC,
		ST_DISC,
		ST_PHY_POWERED_DOWN_STATE,
		ST_WAKE,
		ST_TRAIN0,
		ST_WARM
	} state_t;

	// link-facing controls, all registered
	typedef struct packed {
		logic       scramble_en;
		logic       send_disconnect;
		logic [1:0] tx_clk_mode;
		logic       freeze_ack_ptr;
		logic       clear_credits;
		logic       rx_process_en;
		logic       phase_hold_prep;
		logic       rx_lane_in_dis;
		logic       rx_clk_in_dis;
		logic       rx_phy_powered_down_state;
		logic       dll_hold;
		logic       dll_relock;
		logic       inactive_lanes;
		logic       phy_powered_down_state;
		logic       warm_reset;
		logic       train0_active;
		logic       phase_seek;
		logic       full_t0_sel;
	} link_ctl_t;

	// events from the transmit and receive datapaths
	typedef struct packed {
		logic pkt_in_progress;
		logic disc_pkt_sent;
		logic rx_disc_pkt_seen;
	} link_evt_t;

endpackage

//--- logic/sync_bits.sv
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels, not pulses
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module sync_bits #(
	parameter int unsigned W   = 2,
	parameter logic [W-1:0] RST = '1
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_st_t;

	sync_st_t st_q;
	sync_st_t st_d;

	// per-bit two-stage chain
	always_comb begin
		st_d        = st_q;
		st_d.meta   = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= {RST, RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;

endmodule

//--- logic/link_stop_disconnect_fsm.sv
// Purpose: link state logic from stop request through disconnected to first training
// Assumes: stop and restart pins are asynchronous; datapath events are on aclk
// Notes:   registers over AXI4-Lite; full training time is a parameter for simulation
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps

module link_stop_disconnect_fsm #(
	parameter int unsigned FULL_T0_CYCLES   = link_stop_pkg::FULL_T0_CYC,
	parameter bit          CLK_RESTORE_SLOW = 1'b0
) (
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// sideband pins
	input  wire logic                     link_stop_request_n,
	input  wire logic                     restart_request_n,
	// datapath events and controls
	input  wire link_stop_pkg::link_evt_t evt,
	output link_stop_pkg::link_ctl_t      ctl,
	// axi4-lite write address
	input  wire logic [11:0]              awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	// axi4-lite write data
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	// axi4-lite write response
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	// axi4-lite read address
	input  wire logic [11:0]              araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	// axi4-lite read data
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready
);
	import link_stop_pkg::*;

	typedef struct packed {
		state_t      state;
		logic [31:0] tmr;
		logic [2:0]  pkts;
		logic [7:0]  dcyc;
		logic [31:0] idle;
		logic        prep_done;
		logic [7:0]  ctrl;
		logic [31:0] short_t0;
		logic [31:0] idle_max;
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		link_ctl_t   ctl;
	} st_t;

	st_t        st_q;
	st_t        st_d;
	logic [1:0] pins_s;
	logic       stop_n;
	logic       restart_n;

	// both pins cross into aclk before any decision looks at them
	sync_bits #(
		.W   (2),
		.RST (2'h3)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({link_stop_request_n, restart_request_n}),
		.sync_out (pins_s)
	);
	assign stop_n    = pins_s[1];
	assign restart_n = pins_s[0];

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// next-state logic: bus slave, link sequencer, then the registered controls
	always_comb begin
		logic [31:0] wv;
		logic [1:0]  txs;
		logic [1:0]  rxs;
		logic        in_fsm_reset;
		wv           = 32'h0000_0000;
		txs          = st_q.ctrl[TXSEL_LSB +: 2];
		rxs          = st_q.ctrl[RXSEL_LSB +: 2];
		in_fsm_reset = 1'b0;
		st_d         = st_q;

		// write channel: address and data taken in either order
		if (awvalid && awready) begin
			st_d.aw_got  = 1'b1;
			st_d.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			st_d.w_got  = 1'b1;
			st_d.w_data = wdata;
			st_d.w_strb = wstrb;
		end
		if (st_q.bvalid && bready) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.aw_got && st_q.w_got) begin
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp  = RESP_OKAY;
			if (st_q.aw_addr == CTRL_OFS) begin
				wv = merge({24'h000000, st_q.ctrl}, st_q.w_data, st_q.w_strb);
				st_d.ctrl = wv[7:0];
				if (CLK_RESTORE_SLOW) begin
					st_d.ctrl[TXSEL_LSB + 1] = 1'b0;
					st_d.ctrl[RXSEL_LSB + 1] = 1'b0;
				end
			end else if (st_q.aw_addr == SHORT_T0_OFS) begin
				st_d.short_t0 = merge(st_q.short_t0, st_q.w_data, st_q.w_strb);
			end else if (st_q.aw_addr == IDLE_MAX_OFS) begin
				st_d.idle_max = merge(st_q.idle_max, st_q.w_data, st_q.w_strb);
			end else if (st_q.aw_addr != STATUS_OFS && st_q.aw_addr != IDLE_CNT_OFS) begin
				st_d.bresp = RESP_SLVERR;
			end
		end

		// read channel: one cycle after the address is taken
		if (st_q.rvalid && rready) begin
			st_d.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = RESP_OKAY;
			if (araddr == CTRL_OFS) begin
				st_d.rdata = {24'h000000, st_q.ctrl};
			end else if (araddr == SHORT_T0_OFS) begin
				st_d.rdata = st_q.short_t0;
			end else if (araddr == IDLE_MAX_OFS) begin
				st_d.rdata = st_q.idle_max;
			end else if (araddr == STATUS_OFS) begin
				st_d.rdata = {23'h000000, st_q.prep_done, st_q.pkts, 1'b0, st_q.state};
			end else if (araddr == IDLE_CNT_OFS) begin
				st_d.rdata = st_q.idle;
			end else begin
				st_d.rdata = 32'h0000_0000;
				st_d.rresp = RESP_SLVERR;
			end
		end

		// link sequencer
		st_d.tmr = st_q.tmr + 32'h0000_0001;
		case (st_q.state)
			ST_OPER: begin
				if (!stop_n) begin
					st_d.state     = ST_STOP;
					st_d.tmr       = 32'h0000_0000;
					st_d.prep_done = 1'b0;
				end
			end
			ST_STOP: begin
				// current packet finishes before disconnect packets start
				if (!evt.pkt_in_progress) begin
					st_d.state = ST_SEND_DISC;
					st_d.pkts  = 3'h0;
					st_d.dcyc  = 8'h00; // the disconnect time starts after the last packet
				end
			end
			ST_SEND_DISC: begin
				if (evt.disc_pkt_sent && st_q.pkts != 3'h7) begin
					st_d.pkts = st_q.pkts + 3'h1;
				end
				if (st_q.dcyc != 8'hff) begin
					st_d.dcyc = st_q.dcyc + 8'h01;
				end
				// leave once 200ns are past and four packets are out; a slow
				// packet count may stretch past 300ns, which is the lesser harm
				if (32'(st_q.dcyc) >= 32'(DISC_MIN_CYC) &&
				    32'(st_q.pkts) >= 32'(DISC_MIN_PKTS)) begin
					st_d.state = ST_DISC;
					st_d.idle  = 32'h0000_0000;
				end
			end
			ST_DISC: begin
				if (st_q.idle != 32'hffff_ffff) begin
					st_d.idle = st_q.idle + 32'h0000_0001;
				end
				if (st_q.ctrl[TRANSMIT_OFF_CTL_BIT]) begin
					st_d.state = ST_PHY_POWERED_DOWN_STATE;
				end else if (stop_n) begin
					st_d.state = ST_WAKE;
					st_d.tmr   = 32'h0000_0000;
				end
			end
			ST_PHY_POWERED_DOWN_STATE: begin
				st_d.state = ST_PHY_POWERED_DOWN_STATE;
			end
			ST_WAKE: begin
				if (!stop_n) begin
					st_d.state = ST_DISC;
				end else if (st_q.tmr >= 32'(RX_WAIT_CYC) - 32'h0000_0001) begin
					st_d.state = ST_TRAIN0;
					st_d.tmr   = 32'h0000_0000;
					st_d.ctl.full_t0_sel = (st_q.idle > st_q.idle_max);
				end
			end
			ST_TRAIN0: begin
				if ((st_q.ctl.full_t0_sel && st_q.tmr >= 32'(FULL_T0_CYCLES)) ||
				    (!st_q.ctl.full_t0_sel && st_q.tmr >= st_q.short_t0)) begin
					st_d.state = ST_OPER;
				end
			end
			ST_WARM: begin
				if (restart_n) begin
					st_d.state = ST_OPER;
				end
			end
			default: begin
				st_d.state = ST_OPER;
			end
		endcase

		// restart wins over every other exit of the stop and idle states
		in_fsm_reset = (st_q.state == ST_STOP) || (st_q.state == ST_SEND_DISC) ||
		               (st_q.state == ST_DISC) || (st_q.state == ST_PHY_POWERED_DOWN_STATE) ||
		               (st_q.state == ST_WAKE);
		if (!restart_n && in_fsm_reset) begin
			st_d.state = ST_WARM;
		end

		// phase-hold preparation is flagged at the end of its 100ns budget
		if (st_q.state == ST_STOP || st_q.state == ST_SEND_DISC) begin
			if (st_q.tmr >= 32'(PHASE_PREP_CYC) - 32'h0000_0001) begin
				st_d.prep_done = 1'b1;
			end
		end

		// registered link controls follow the next state
		st_d.ctl.scramble_en     = 1'b1;
		st_d.ctl.send_disconnect = 1'b0;
		st_d.ctl.tx_clk_mode     = TRANSMIT_CLOCK_PROG;
		st_d.ctl.freeze_ack_ptr  = 1'b0;
		st_d.ctl.clear_credits   = 1'b0;
		st_d.ctl.rx_process_en   = 1'b1;
		st_d.ctl.phase_hold_prep = 1'b0;
		st_d.ctl.rx_lane_in_dis  = 1'b0;
		st_d.ctl.rx_clk_in_dis   = 1'b0;
		st_d.ctl.rx_phy_powered_down_state      = 1'b0;
		st_d.ctl.dll_hold        = 1'b1;
		st_d.ctl.dll_relock      = 1'b0;
		st_d.ctl.inactive_lanes  = 1'b0;
		st_d.ctl.phy_powered_down_state         = 1'b0;
		st_d.ctl.warm_reset      = 1'b0;
		st_d.ctl.train0_active   = 1'b0;
		st_d.ctl.phase_seek      = 1'b0;
		case (st_d.state)
			ST_STOP, ST_SEND_DISC: begin
				st_d.ctl.tx_clk_mode     = TRANSMIT_CLOCK_HOLD;
				st_d.ctl.freeze_ack_ptr  = 1'b1;
				st_d.ctl.clear_credits   = (st_q.state == ST_OPER);
				st_d.ctl.phase_hold_prep = 1'b1;
				st_d.ctl.rx_process_en   = st_q.ctl.rx_process_en &&
				                           !evt.rx_disc_pkt_seen;
				// disconnect packets keep the lanes toggling until the state ends
				st_d.ctl.send_disconnect = (st_d.state == ST_SEND_DISC);
			end
			ST_DISC, ST_WAKE: begin
				st_d.ctl.freeze_ack_ptr = 1'b1;
				st_d.ctl.rx_process_en  = 1'b0;
				st_d.ctl.inactive_lanes = st_q.ctrl[NARROW_BIT];
				if (st_d.state == ST_WAKE) begin
					st_d.ctl.tx_clk_mode = TRANSMIT_CLOCK_PROG;
					st_d.ctl.dll_relock  = (st_q.state == ST_DISC) &&
					                       st_q.ctrl[FREQ_BIT];
					st_d.ctl.phase_seek  = 1'b0;
				end else begin
					if (txs == LS2 || txs == LS3) begin
						st_d.ctl.tx_clk_mode = TRANSMIT_CLOCK_STOP;
					end else if (txs == LS1 && st_q.ctrl[DIVCLK_BIT]) begin
						st_d.ctl.tx_clk_mode = TRANSMIT_CLOCK_DIV;
					end
					st_d.ctl.rx_lane_in_dis = (rxs != LS0);
					st_d.ctl.rx_clk_in_dis  = (rxs == LS2) || (rxs == LS3);
					st_d.ctl.rx_phy_powered_down_state     = (rxs == LS3);
					st_d.ctl.dll_hold       = (rxs != LS2) && (rxs != LS3) &&
					                          !st_q.ctrl[FREQ_BIT];
					st_d.ctl.dll_relock     = 1'b0;
				end
				st_d.ctl.scramble_en = 1'b1;
			end
			ST_PHY_POWERED_DOWN_STATE: begin
				st_d.ctl.phy_powered_down_state       = 1'b1;
				st_d.ctl.tx_clk_mode   = TRANSMIT_CLOCK_STOP;
				st_d.ctl.rx_process_en = 1'b0;
				st_d.ctl.dll_hold      = 1'b0;
			end
			ST_TRAIN0: begin
				st_d.ctl.train0_active = 1'b1;
				st_d.ctl.phase_seek    = 1'b1;
				st_d.ctl.rx_process_en = 1'b0;
			end
			ST_WARM: begin
				st_d.ctl.warm_reset    = 1'b1;
				st_d.ctl.rx_process_en = 1'b0;
			end
			default: begin
				st_d.ctl.scramble_en = 1'b1;
			end
		endcase
	end

	// single state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q          <= '0;
			st_q.state    <= ST_OPER;
			st_q.ctrl     <= CTRL_RST;
			st_q.short_t0 <= SHORT_T0_RST;
			st_q.idle_max <= IDLE_MAX_RST;
			st_q.ctl.scramble_en   <= 1'b1;
			st_q.ctl.rx_process_en <= 1'b1;
			st_q.ctl.dll_hold      <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// bus handshakes; ready drops while a response is pending
	assign awready = !st_q.aw_got && !st_q.bvalid;
	assign wready  = !st_q.w_got && !st_q.bvalid;
	assign bvalid  = st_q.bvalid;
	assign bresp   = st_q.bresp;
	assign arready = !st_q.rvalid;
	assign rvalid  = st_q.rvalid;
	assign rdata   = st_q.rdata;
	assign rresp   = st_q.rresp;
	assign ctl     = st_q.ctl;

endmodule

//--- dv/link_peer_model.sv
// Purpose: peer link traffic seen by the stop/disconnect logic
// Assumes: ctl outputs are registered, so evt may follow them combinationally
// Notes:   slow spaces disconnect packets so the count outlasts the minimum time
`timescale 1ns/1ps

module link_peer_model
	import link_stop_pkg::*;
(
	// clock and reset
	input  wire logic      aclk,
	input  wire logic      aresetn,
	// pacing and link controls
	input  wire logic      slow,
	input  wire link_ctl_t ctl,
	// events back to the block
	output link_evt_t      evt
);
	logic [4:0] cnt_q;
	logic       busy_q;

	// packets start only while the ack pointer is not frozen but always run to their end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= 5'h00;
			busy_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_q + 5'h01;
			busy_q <= (cnt_q == 5'h1f) ? !ctl.freeze_ack_ptr : (cnt_q == 5'h05 ? 1'b0 : busy_q);
		end
	end

	// one disconnect packet each eight cycles, or each sixteen when slow
	assign evt.pkt_in_progress  = busy_q;
	assign evt.disc_pkt_sent    = ctl.send_disconnect &&
		(slow ? cnt_q[3:0] == 4'hf : cnt_q[2:0] == 3'h7);
	assign evt.rx_disc_pkt_seen = ctl.phase_hold_prep && cnt_q == 5'h0a;
endmodule

//--- dv/link_stop_disconnect_fsm_props.sv
// Purpose: timing relations of the stop/disconnect controls
// Assumes: pins pass a two-flop synchroniser before the state logic
// Notes:   windows allow for that synchroniser and the registered ctl
`timescale 1ns/1ps

module link_stop_fsm_props
	import link_stop_pkg::*;
#(
	parameter int unsigned FULL_T0_CYCLES   = FULL_T0_CYC,
	parameter bit          CLK_RESTORE_SLOW = 1'b0
) (
	// clock and reset
	input  wire logic      aclk,
	input  wire logic      aresetn,
	// pins and link side
	input  wire logic      link_stop_request_n,
	input  wire logic      restart_request_n,
	input  wire link_evt_t evt,
	input  wire link_ctl_t ctl
);
	localparam int TX_BOUND = 180;
	typedef struct packed {
		logic [7:0]  tmr;
		logic [2:0]  pkts;
		logic [15:0] wake;
		logic        pin;
	} aux_t;
	aux_t q, d;

	// time and packets since stop entry, cycles since the stop pin rose
	always_comb begin
		d      = q;
		d.pin  = link_stop_request_n;
		d.tmr  = ctl.clear_credits ? 8'h00 : q.tmr + {7'h0, q.tmr != 8'hff};
		d.pkts = ctl.clear_credits ? 3'h0 : q.pkts + {2'h0, evt.disc_pkt_sent && q.pkts != 3'h7};
		d.wake = (link_stop_request_n && !q.pin) ? 16'h0000 : q.wake + {15'h0, q.wake != 16'hffff};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) q <= '{8'h00, 3'h0, 16'h0000, 1'b1};
		else q <= d;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_scramble_kept: assert property (ctl.scramble_en)
		else $error("scrambling dropped");
	a_stop_entry: assert property ($fell(link_stop_request_n) && restart_request_n &&
		!ctl.freeze_ack_ptr && !ctl.train0_active && !ctl.warm_reset && !ctl.phy_powered_down_state
		|-> ##[1:12] ctl.clear_credits) else $error("stop request not taken");
	a_entry_set: assert property (ctl.clear_credits |-> ctl.freeze_ack_ptr &&
		ctl.phase_hold_prep && ctl.tx_clk_mode == TRANSMIT_CLOCK_HOLD) else $error("bad stop entry");
	a_credit_pulse: assert property (ctl.clear_credits |=> !ctl.clear_credits)
		else $error("credit clear not a pulse");
	a_rx_stop: assert property (evt.rx_disc_pkt_seen && ctl.phase_hold_prep
		|-> ##[1:2] !ctl.rx_process_en) else $error("rx kept processing");
	a_disc_count: assert property ($fell(ctl.send_disconnect) && !ctl.warm_reset
		|-> q.pkts >= DISC_MIN_PKTS && q.tmr >= DISC_MIN_CYC - 1) else $error("short disconnect");
	a_warm_entry: assert property ($fell(restart_request_n) &&
		(ctl.freeze_ack_ptr || ctl.phy_powered_down_state) |-> ##[1:5] ctl.warm_reset) else $error("no warm reset");
	a_wake_restore: assert property ($rose(link_stop_request_n) && ctl.freeze_ack_ptr &&
		!ctl.phase_hold_prep && !ctl.warm_reset |-> ##[1:TX_BOUND] ctl.tx_clk_mode == TRANSMIT_CLOCK_PROG)
		else $error("clock not restored");
	a_rx_wait: assert property ($rose(ctl.train0_active) |-> q.wake >= RX_WAIT_CYC - 1)
		else $error("training before rx wait");
	a_lane_order: assert property (ctl.rx_clk_in_dis |-> ctl.rx_lane_in_dis)
		else $error("clock input off with lanes on");
	a_phy_lanes: assert property (ctl.rx_phy_powered_down_state |-> ctl.rx_clk_in_dis)
		else $error("phy_powered_down_state with clock input on");

	c_stop: cover property (ctl.clear_credits);
	c_phy_powered_down_state: cover property (ctl.phy_powered_down_state);
	c_warm: cover property (ctl.warm_reset);
	c_train: cover property ($rose(ctl.train0_active));
endmodule

bind link_stop_disconnect_fsm link_stop_fsm_props #(
	.FULL_T0_CYCLES(FULL_T0_CYCLES),
	.CLK_RESTORE_SLOW(CLK_RESTORE_SLOW)
) u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.link_stop_request_n(link_stop_request_n),
	.restart_request_n(restart_request_n),
	.evt(evt),
	.ctl(ctl)
);

//--- dv/link_stop_disconnect_fsm_tb_top.sv
// Purpose: register and disconnect sequences against the stop/disconnect block
// Assumes: full training time shortened to FT0 cycles
// Notes:   waits sample at the falling edge, drives follow the rising edge
`timescale 1ns/1ps

module link_stop_disconnect_fsm_tb_top;
	import link_stop_pkg::*;
	localparam int unsigned FT0 = 50;
	logic aclk = 0, aresetn = 0, stop_n = 1, rst_n = 1, slow = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0]  wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	link_evt_t evt;
	link_ctl_t ctl;
	int miscompares = 0, checks_done = 0, disc_len = 0, relocks = 0;

	always #2.5 aclk = ~aclk;

	link_stop_disconnect_fsm #(.FULL_T0_CYCLES(FT0), .CLK_RESTORE_SLOW(1'b0)) uut (
		.aclk(aclk), .aresetn(aresetn), .link_stop_request_n(stop_n),
		.restart_request_n(rst_n), .evt(evt), .ctl(ctl),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	link_peer_model peer (.aclk(aclk), .aresetn(aresetn), .slow(slow), .ctl(ctl), .evt(evt));

	// disconnect length since stop entry and relock pulses
	always @(posedge aclk) begin
		if (ctl.clear_credits) disc_len <= 0;
		else if (ctl.send_disconnect) disc_len <= disc_len + 1;
		if (ctl.dll_relock) relocks <= relocks + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// both halves offered together; each released at the edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		tb = 0;
		@(posedge aclk);
		awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tb) bready <= 0;
		end
		chk(r, er);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] v;
		logic [1:0] r;
		tr = 0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid & arready; tr = rvalid; v = rdata; r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 0;
			if (tr) rready <= 0;
		end
		chk(v, e);
		chk(r, er);
	endtask

	// one stop, disconnected, wake and training pass with control value c
	task automatic cycle_link(input logic [7:0] c, input logic sl, input int unsigned t0);
		int n, r;
		r = relocks;
		wr(CTRL_OFS, {24'h0, c}, RESP_OKAY);
		@(posedge aclk) begin slow <= sl; stop_n <= 1'b0; end
		repeat (100) if (!ctl.send_disconnect) @(negedge aclk);
		repeat (300) if (ctl.send_disconnect) @(negedge aclk);
		@(negedge aclk);
		chk(ctl.rx_lane_in_dis, c[4:3] != LS0);
		chk(ctl.rx_clk_in_dis, c[4]);
		chk(ctl.rx_phy_powered_down_state, c[4:3] == LS3);
		chk(ctl.inactive_lanes, c[6]);
		chk(ctl.dll_hold, !(c[4] | c[5]));
		if (c[7] && c[2:1] == LS1) chk(ctl.tx_clk_mode, TRANSMIT_CLOCK_DIV);
		else chk(ctl.tx_clk_mode, c[2] ? TRANSMIT_CLOCK_STOP : TRANSMIT_CLOCK_PROG);
		if (!sl) chk(disc_len <= DISC_MAX_CYC, 1'b1);
		chk(disc_len >= DISC_MIN_CYC, 1'b1);
		// held disconnected 20 more cycles before the stop pin is released
		repeat (20) @(posedge aclk);
		stop_n <= 1'b1;
		repeat (400) if (!ctl.train0_active) @(negedge aclk);
		chk(ctl.phase_seek, 1'b1);
		n = 0;
		while (ctl.train0_active && n < 1000) begin @(negedge aclk); n++; end
		chk(n >= t0 && n <= t0 + 1, 1'b1);
		chk(relocks - r, c[5]);
	endtask

	task automatic to_disc();
		@(posedge aclk) stop_n <= 1'b0;
		repeat (300) if (!ctl.freeze_ack_ptr || ctl.phase_hold_prep) @(negedge aclk);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		results();
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rd_chk(CTRL_OFS, {24'h0, CTRL_RST}, RESP_OKAY);
		rd_chk(SHORT_T0_OFS, SHORT_T0_RST, RESP_OKAY);
		rd_chk(IDLE_MAX_OFS, IDLE_MAX_RST, RESP_OKAY);
		wr(STATUS_OFS, 32'hffff_ffff, RESP_OKAY);
		rd_chk(STATUS_OFS, 32'h0000_0000, RESP_OKAY);
		wr(12'h020, 32'h0000_0001, RESP_SLVERR);
		rd_chk(12'h020, 32'h0000_0000, RESP_SLVERR);
		$display("test registers done");
		// every receive select with the divided transmit clock
		for (int i = 0; i < 4; i++) cycle_link(8'(8'h82 | (i << 3)), 1'b0, SHORT_T0_RST);
		cycle_link(8'h64, 1'b1, SHORT_T0_RST);
		wr(IDLE_MAX_OFS, 32'h0000_0000, RESP_OKAY);
		cycle_link(8'h00, 1'b0, FT0);
		$display("test disconnect done");
		// transmit off parks the link until a warm reset
		wr(IDLE_MAX_OFS, IDLE_MAX_RST, RESP_OKAY);
		to_disc();
		wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
		repeat (4) @(negedge aclk);
		chk(ctl.phy_powered_down_state, 1'b1);
		@(posedge aclk) stop_n <= 1'b1;
		repeat (300) @(negedge aclk);
		chk(ctl.phy_powered_down_state, 1'b1);
		@(posedge aclk) rst_n <= 1'b0;
		repeat (8) @(negedge aclk);
		chk(ctl.warm_reset, 1'b1);
		@(posedge aclk) rst_n <= 1'b1;
		wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
		repeat (8) @(negedge aclk);
		chk(ctl.warm_reset, 1'b0);
		// restart while disconnect packets are going out
		@(posedge aclk) stop_n <= 1'b0;
		repeat (100) if (!ctl.send_disconnect) @(negedge aclk);
		@(posedge aclk) rst_n <= 1'b0;
		repeat (8) @(negedge aclk);
		chk(ctl.warm_reset, 1'b1);
		@(posedge aclk) begin rst_n <= 1'b1; stop_n <= 1'b1; end
		repeat (8) @(negedge aclk);
		$display("test power off and restart done");
		results();
	end
endmodule
